//--- inc/lock_status_pkg.sv
// Constants, register map and field layout of the lock status and misc control block.
// Assumes a configuration port that delivers decoded register reads and writes.

package lock_status_pkg;

  localparam int ADDR_W = 13;

  localparam logic [12:0] STATUS_PIN2_CONFIG_OFFSET     = 13'h16e;
  localparam logic [12:0] PLL_POWER_DOWN_CTRL_OFFSET    = 13'h173;
  localparam logic [12:0] REF_DIVIDER_RESET_CTRL_OFFSET = 13'h177;
  localparam logic [12:0] LOCK_LOST_CLEAR_CTRL_OFFSET   = 13'h182;
  localparam logic [12:0] LOCK_READBACK_OFFSET          = 13'h183;

  localparam int SRC_SEL_LSB       = 3;
  localparam int SRC_SEL_MSB       = 7;
  localparam int DRIVE_LSB         = 0;
  localparam int DRIVE_MSB         = 2;
  localparam int PRESCALER_PD_BIT  = 6;
  localparam int LOOP_PD_BIT       = 5;
  localparam int FEEDBACK_PD_BIT   = 4;
  localparam int REF_RST_BIT       = 5;
  localparam int CLR_FIRST_BIT     = 1;
  localparam int CLR_SECOND_BIT    = 0;
  localparam int RB_FIRST_LOST_BIT = 3;
  localparam int RB_FIRST_LOCK_BIT = 2;
  localparam int RB_SECOND_LOST_BIT = 1;
  localparam int RB_SECOND_LOCK_BIT = 0;

  localparam logic [4:0] SRC_SEL_RST = 5'h00;
  localparam logic [2:0] DRIVE_RST   = 3'h6;
  localparam logic       PD_RST      = 1'b1;
  localparam logic       REF_RST_RST = 1'b0;
  localparam logic       CLR_RST     = 1'b0;

  localparam logic [4:0] SEL_SECOND_LOCK  = 5'h02;
  localparam logic [4:0] SEL_BOTH_LOCK    = 5'h03;
  localparam logic [4:0] SEL_SECOND_REF_2 = 5'h11;
  localparam logic [4:0] SEL_SECOND_REF_4 = 5'h12;
  localparam logic [4:0] SEL_LAST         = 5'h12;

  localparam logic [2:0] DRIVE_PUSH_PULL  = 3'h3;
  localparam logic [2:0] DRIVE_INVERTED   = 3'h4;
  localparam logic [2:0] DRIVE_OPEN_DRAIN = 3'h6;

  // Number of asynchronous misc status inputs, besides the two lock detects, that feed the source multiplexer.
  localparam int MISC_W = 14;

  function automatic logic selects_second_lock(input logic [4:0] sel);
    selects_second_lock = (sel == SEL_SECOND_LOCK) || (sel == SEL_BOTH_LOCK);
  endfunction

endpackage

//--- design/lock_lost_flag.sv
// One sticky lock-lost flag with its lock detect synchroniser.
// Assumes the lock detect arrives asynchronously and the clear comes from a register.
`timescale 1ns/1ps
`default_nettype none

module lock_lost_flag (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic lock_detect_raw,
  input  wire logic clear,
  output logic      lost_flag,
  output logic      lock_level
);

  typedef struct packed {
    logic [2:0] sync;
    logic       level;
    logic       flag;
  } flag_state_type;

  flag_state_type st_q;
  flag_state_type st_d;
  logic           fall;

  ////////////////////////////////////////////////////////////////////////////////

  // The first stage feeds only the second; the level moves once stages two and three agree.
  always_comb
  begin
    st_d      = st_q;
    st_d.sync = {st_q.sync[1:0], lock_detect_raw};
    fall      = st_q.level && !st_q.sync[1] && !st_q.sync[2];
    if (st_q.sync[1] == st_q.sync[2])
    begin
      st_d.level = st_q.sync[2];
    end
    // The held clear wins over a falling edge in the same cycle.
    if (clear)
    begin
      st_d.flag = 1'b0;
    end
    else if (fall)
    begin
      st_d.flag = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign lost_flag  = st_q.flag;
  assign lock_level = st_q.level;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence falling_seen;
    ce && !clear && fall;
  endsequence

  flag_held_clear_a: assert property (ce && clear |=> !st_q.flag)
    else $error("Lock-lost flag not held clear.");
  flag_sets_fall_a: assert property (falling_seen |=> st_q.flag)
    else $error("Lock-lost flag missed a falling edge.");
  flag_only_edge_a: assert property ($rose(st_q.flag) |-> $past(fall) && !$past(clear))
    else $error("Lock-lost flag set without a falling edge.");

endmodule // lock_lost_flag

`default_nettype wire

//--- design/lock_status_misc_control.sv
// Status pin multiplexer, power-down controls and lock-lost flags of the clock conditioner.
// Assumes decoded register accesses from the configuration port and asynchronous status inputs.
`timescale 1ns/1ps
`default_nettype none

module lock_status_misc_control (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [12:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [4:0]  first_status_source_select,
  input  wire logic        second_lock_detect_force_on,
  input  wire logic        first_digital_lock_detect,
  input  wire logic        second_digital_lock_detect,
  input  wire logic        holdover_status,
  input  wire logic        dac_locked,
  input  wire logic        serial_readback,
  input  wire logic        dac_rail,
  input  wire logic        dac_low,
  input  wire logic        dac_high,
  input  wire logic [7:0]  divider_test,
  output logic             second_status_pin_o,
  output logic             second_status_pin_oe,
  output logic             second_loop_prescaler_powerdown,
  output logic             second_loop_powerdown,
  output logic             feedback_input_powerdown,
  output logic             first_loop_ref_divider_reset,
  output logic             second_lock_detect_run
);

  typedef struct packed {
    logic [4:0]                        src_sel;
    logic [2:0]                        drive;
    logic                              pre_pd;
    logic                              loop_pd;
    logic                              fb_pd;
    logic                              ref_rst;
    logic                              clr_first;
    logic                              clr_second;
    logic [lock_status_pkg::MISC_W-1:0] s1;
    logic [lock_status_pkg::MISC_W-1:0] s2;
    logic [lock_status_pkg::MISC_W-1:0] s3;
    logic [lock_status_pkg::MISC_W-1:0] filt;
    logic                              run;
    logic                              pin_o;
    logic                              pin_oe;
    logic [7:0]                        rdata;
    logic                              rvalid;
  } state_type;

  state_type  st_q;
  state_type  st_d;
  logic [1:0] lost_flag;
  logic [1:0] lock_level;
  logic [1:0] lock_raw;
  logic [1:0] clear_ctrl;
  logic [lock_status_pkg::MISC_W-1:0] misc_raw;
  logic [18:0] source;
  logic        level;
  logic        wr_cfg;
  logic        wr_pd;
  logic        wr_rst;
  logic        wr_clr;

  ////////////////////////////////////////////////////////////////////////////////

  assign lock_raw   = {second_digital_lock_detect, first_digital_lock_detect};
  assign clear_ctrl = {st_q.clr_second, st_q.clr_first};
  assign misc_raw   = {divider_test, dac_high, dac_low, dac_rail, serial_readback, dac_locked,
                       holdover_status};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_flag
      lock_lost_flag u_flag (
        .clk             (clk),
        .rst_n           (rst_n),
        .ce              (ce),
        .lock_detect_raw (lock_raw[gi]),
        .clear           (clear_ctrl[gi]),
        .lost_flag       (lost_flag[gi]),
        .lock_level      (lock_level[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////

  assign wr_cfg = reg_wr && (reg_addr == lock_status_pkg::STATUS_PIN2_CONFIG_OFFSET);
  assign wr_pd  = reg_wr && (reg_addr == lock_status_pkg::PLL_POWER_DOWN_CTRL_OFFSET);
  assign wr_rst = reg_wr && (reg_addr == lock_status_pkg::REF_DIVIDER_RESET_CTRL_OFFSET);
  assign wr_clr = reg_wr && (reg_addr == lock_status_pkg::LOCK_LOST_CLEAR_CTRL_OFFSET);

  // Index of each source equals its select code; codes 0 and 6 drive low.
  assign source = {st_q.filt[13:6], st_q.filt[5:3], st_q.filt[2], 1'b0, st_q.filt[1],
                   st_q.filt[0], lock_level[0] & lock_level[1], lock_level[1], lock_level[0],
                   1'b0};

  always_comb
  begin
    st_d = st_q;
    // Misc inputs: three stages, and a change counts once stages two and three agree.
    st_d.s1   = misc_raw;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.filt = ((st_q.s2 ~^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.filt);
    if (wr_cfg)
    begin
      st_d.src_sel = reg_wdata[lock_status_pkg::SRC_SEL_MSB:lock_status_pkg::SRC_SEL_LSB];
      st_d.drive   = reg_wdata[lock_status_pkg::DRIVE_MSB:lock_status_pkg::DRIVE_LSB];
    end
    if (wr_pd)
    begin
      st_d.pre_pd  = reg_wdata[lock_status_pkg::PRESCALER_PD_BIT];
      st_d.loop_pd = reg_wdata[lock_status_pkg::LOOP_PD_BIT];
      st_d.fb_pd   = reg_wdata[lock_status_pkg::FEEDBACK_PD_BIT];
    end
    if (wr_rst)
    begin
      st_d.ref_rst = reg_wdata[lock_status_pkg::REF_RST_BIT];
    end
    if (wr_clr)
    begin
      st_d.clr_first  = reg_wdata[lock_status_pkg::CLR_FIRST_BIT];
      st_d.clr_second = reg_wdata[lock_status_pkg::CLR_SECOND_BIT];
    end
    // The second detector runs when forced on or when either pin shows its lock.
    st_d.run = second_lock_detect_force_on
               || lock_status_pkg::selects_second_lock(st_q.src_sel)
               || lock_status_pkg::selects_second_lock(first_status_source_select);
    // Divider test codes 17 and 18 share logic with the first pin's lock choices.
    if (st_q.src_sel > lock_status_pkg::SEL_LAST)
    begin
      level = 1'b0;
    end
    else if (((st_q.src_sel == lock_status_pkg::SEL_SECOND_REF_2)
              || (st_q.src_sel == lock_status_pkg::SEL_SECOND_REF_4))
             && lock_status_pkg::selects_second_lock(first_status_source_select))
    begin
      level = 1'b0;
    end
    else
    begin
      level = source[st_q.src_sel];
    end
    // Reserved drive codes leave the pin undriven.
    unique case (st_q.drive)
      lock_status_pkg::DRIVE_PUSH_PULL:
      begin
        st_d.pin_o  = level;
        st_d.pin_oe = 1'b1;
      end
      lock_status_pkg::DRIVE_INVERTED:
      begin
        st_d.pin_o  = !level;
        st_d.pin_oe = 1'b1;
      end
      lock_status_pkg::DRIVE_OPEN_DRAIN:
      begin
        st_d.pin_o  = 1'b0;
        st_d.pin_oe = !level;
      end
      default:
      begin
        st_d.pin_o  = 1'b0;
        st_d.pin_oe = 1'b0;
      end
    endcase
    st_d.rvalid = reg_rd;
    if (reg_rd)
    begin
      unique case (reg_addr)
        lock_status_pkg::STATUS_PIN2_CONFIG_OFFSET:
          st_d.rdata = {st_q.src_sel, st_q.drive};
        lock_status_pkg::PLL_POWER_DOWN_CTRL_OFFSET:
          st_d.rdata = {1'b0, st_q.pre_pd, st_q.loop_pd, st_q.fb_pd, 4'h0};
        lock_status_pkg::REF_DIVIDER_RESET_CTRL_OFFSET:
          st_d.rdata = {2'h0, st_q.ref_rst, 5'h00};
        lock_status_pkg::LOCK_LOST_CLEAR_CTRL_OFFSET:
          st_d.rdata = {6'h00, st_q.clr_first, st_q.clr_second};
        // A stopped second detector reads as unlocked rather than stale.
        lock_status_pkg::LOCK_READBACK_OFFSET:
          st_d.rdata = {4'h0, lost_flag[0], lock_level[0], lost_flag[1],
                        lock_level[1] & st_q.run};
        default:
          st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q            <= '0;
      st_q.src_sel    <= lock_status_pkg::SRC_SEL_RST;
      st_q.drive      <= lock_status_pkg::DRIVE_RST;
      st_q.pre_pd     <= lock_status_pkg::PD_RST;
      st_q.loop_pd    <= lock_status_pkg::PD_RST;
      st_q.fb_pd      <= lock_status_pkg::PD_RST;
      st_q.ref_rst    <= lock_status_pkg::REF_RST_RST;
      st_q.clr_first  <= lock_status_pkg::CLR_RST;
      st_q.clr_second <= lock_status_pkg::CLR_RST;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign reg_rdata                       = st_q.rdata;
  assign reg_rvalid                      = st_q.rvalid;
  assign second_status_pin_o             = st_q.pin_o;
  assign second_status_pin_oe            = st_q.pin_oe;
  assign second_loop_prescaler_powerdown = st_q.pre_pd;
  assign second_loop_powerdown           = st_q.loop_pd;
  assign feedback_input_powerdown        = st_q.fb_pd;
  assign first_loop_ref_divider_reset    = st_q.ref_rst;
  assign second_lock_detect_run          = st_q.run;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence cfg_write;
    ce && wr_cfg;
  endsequence

  sequence pd_write;
    ce && wr_pd;
  endsequence

  src_select_write_a: assert property (cfg_write |=> st_q.src_sel
      == $past(reg_wdata[lock_status_pkg::SRC_SEL_MSB:lock_status_pkg::SRC_SEL_LSB]))
    else $error("Source select did not take the written value.");
  test_output_gate_a: assert property (ce && st_q.drive == lock_status_pkg::DRIVE_PUSH_PULL
      && st_q.src_sel == lock_status_pkg::SEL_SECOND_REF_4
      && lock_status_pkg::selects_second_lock(first_status_source_select)
      |=> !second_status_pin_o)
    else $error("Divider test output passed while gated.");
  open_drain_drive_a: assert property (ce && st_q.drive == lock_status_pkg::DRIVE_OPEN_DRAIN
      |=> !second_status_pin_o)
    else $error("Open drain pin drove high.");
  power_down_write_a: assert property (pd_write |=> {second_loop_prescaler_powerdown,
      second_loop_powerdown, feedback_input_powerdown}
      == $past(reg_wdata[lock_status_pkg::PRESCALER_PD_BIT:lock_status_pkg::FEEDBACK_PD_BIT]))
    else $error("Power-down outputs do not follow the write.");
  ref_reset_write_a: assert property (ce && wr_rst
      |=> first_loop_ref_divider_reset == $past(reg_wdata[lock_status_pkg::REF_RST_BIT]))
    else $error("Reference divider reset does not follow the write.");
  force_on_run_a: assert property (ce && second_lock_detect_force_on
      |=> second_lock_detect_run)
    else $error("Second lock detector not kept running.");
  readback_valid_a: assert property (ce && reg_rd
      && reg_addr == lock_status_pkg::LOCK_READBACK_OFFSET && !st_q.run |=> !reg_rdata[0])
    else $error("Second lock read back while its detector was off.");
  // The flag may set again one cycle after the clear is lowered, so only the next cycle is held.
  clear_holds_flag_a: assert property (ce && st_q.clr_second |=> !lost_flag[1])
    else $error("Second lock-lost flag set while its clear was high.");
  reset_defaults_a: assert property (disable iff (1'b0) !rst_n
      |=> st_q.drive == lock_status_pkg::DRIVE_RST
      && st_q.pre_pd == lock_status_pkg::PD_RST && st_q.loop_pd == lock_status_pkg::PD_RST
      && st_q.fb_pd == lock_status_pkg::PD_RST && st_q.ref_rst == lock_status_pkg::REF_RST_RST
      && st_q.clr_first == lock_status_pkg::CLR_RST && st_q.clr_second == lock_status_pkg::CLR_RST
      && st_q.src_sel == lock_status_pkg::SRC_SEL_RST)
    else $error("Control fields did not load their reset values.");

endmodule // lock_status_misc_control

`default_nettype wire

//--- tb/lock_status_misc_control_tb.sv
// Self-checking testbench for the lock status and misc control block.
// Assumes one 100 MHz clock and drives every register and status input directly.
`timescale 1ns/1ps
`default_nettype none

module lock_status_misc_control_tb;
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic        reg_wr;
  logic        reg_rd;
  logic [12:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [4:0]  first_sel;
  logic        force_on;
  logic [15:0] src;
  logic        pin_o;
  logic        pin_oe;
  logic        pre_pd;
  logic        loop_pd;
  logic        fb_pd;
  logic        ref_rst;
  logic        run;
  logic [7:0]  pd_tab [5] = '{8'h00, 8'h40, 8'h20, 8'h10, 8'hff};
  logic [15:0] pat_tab [3] = '{16'h5555, 16'haaaa, 16'hffff};
  int          miscompares;
  int          tests_run;

  lock_status_misc_control i_dut (
    .clk                             (clk),
    .rst_n                           (rst_n),
    .ce                              (ce),
    .reg_wr                          (reg_wr),
    .reg_rd                          (reg_rd),
    .reg_addr                        (reg_addr),
    .reg_wdata                       (reg_wdata),
    .reg_rdata                       (reg_rdata),
    .reg_rvalid                      (reg_rvalid),
    .first_status_source_select      (first_sel),
    .second_lock_detect_force_on     (force_on),
    .first_digital_lock_detect       (src[0]),
    .second_digital_lock_detect      (src[1]),
    .holdover_status                 (src[2]),
    .dac_locked                      (src[3]),
    .serial_readback                 (src[4]),
    .dac_rail                        (src[5]),
    .dac_low                         (src[6]),
    .dac_high                        (src[7]),
    .divider_test                    (src[15:8]),
    .second_status_pin_o             (pin_o),
    .second_status_pin_oe            (pin_oe),
    .second_loop_prescaler_powerdown (pre_pd),
    .second_loop_powerdown           (loop_pd),
    .feedback_input_powerdown        (fb_pd),
    .first_loop_ref_divider_reset    (ref_rst),
    .second_lock_detect_run          (run)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expected pin level and drive, worked out from the select and drive codes.
  function automatic logic exp_level(input logic [4:0] sel, input logic [15:0] s,
                                     input logic [4:0] fsel);
    if ((sel == 5'h11 || sel == 5'h12) && (fsel == 5'h02 || fsel == 5'h03))
      return 1'b0;
    if (sel >= 5'h0b && sel <= 5'h12)
      return s[sel - 5'h03];
    case (sel)
      5'h01: return s[0];
      5'h02: return s[1];
      5'h03: return s[0] & s[1];
      5'h04: return s[2];
      5'h05: return s[3];
      5'h07: return s[4];
      5'h08: return s[5];
      5'h09: return s[6];
      5'h0a: return s[7];
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [1:0] exp_pin(input logic [2:0] d, input logic l);
    case (d)
      3'h3: return {1'b1, l};
      3'h4: return {1'b1, ~l};
      3'h6: return l ? 2'b00 : 2'b10;
      default: return 2'b00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // The read answer stands for one cycle, so it is sampled just after the taking edge.
  task automatic rd_chk(input string name, input logic [12:0] a, input logic [7:0] m,
                        input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check_val("rvalid", 8'h01, {7'h0, reg_rvalid});
    check_val(name, e, reg_rdata & m);
  endtask

  task automatic drive_in(input logic [15:0] v);
    @(posedge clk);
    src <= v;
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic check_pin(input logic [1:0] e);
    check_val("pin", {6'h0, e}, {6'h0, pin_oe, pin_o & pin_oe});
  endtask

  task automatic flag_seq(input int i);
    int k;
    int sh;
    logic [7:0] m;
    k  = 1 - i;
    sh = 2 * i;
    m  = 8'h03 << sh;
    drive_in(src & ~(16'h1 << k));
    rd_chk("lost_set", 13'h183, m, 8'h02 << sh);
    wr(13'h182, 8'h01 << i);
    rd_chk("lost_clr", 13'h183, m, 8'h00);
    drive_in(src | (16'h1 << k));
    drive_in(src & ~(16'h1 << k));
    rd_chk("lost_held", 13'h183, m, 8'h00);
    wr(13'h182, 8'h00);
    drive_in(src);
    rd_chk("lost_low", 13'h183, m, 8'h00);
    drive_in(src | (16'h1 << k));
    rd_chk("lock_rb", 13'h183, m, 8'h01 << sh);
    drive_in(src & ~(16'h1 << k));
    rd_chk("lost_again", 13'h183, m, 8'h02 << sh);
    drive_in(src | (16'h1 << k));
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    miscompares = 0;
    tests_run   = 0;
    rst_n     = 1'b0;
    ce        = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 13'h0000;
    reg_wdata = 8'h00;
    first_sel = 5'h00;
    force_on  = 1'b0;
    src       = 16'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_pin(2'b10);
    check_val("pd_rst", 8'h0e, {4'h0, pre_pd, loop_pd, fb_pd, ref_rst});
    rd_chk("cfg_rst", 13'h16e, 8'hff, 8'h06);
    rd_chk("pd_rst_rb", 13'h173, 8'hff, 8'h70);
    rd_chk("ref_rst_rb", 13'h177, 8'hff, 8'h00);
    rd_chk("clr_rst_rb", 13'h182, 8'hff, 8'h00);
    foreach (pd_tab[j])
    begin
      wr(13'h173, pd_tab[j]);
      repeat (2) @(posedge clk);
      #1;
      check_val("pd_out", {5'h0, pd_tab[j][6:4]}, {5'h0, pre_pd, loop_pd, fb_pd});
      rd_chk("pd_rb", 13'h173, 8'hff, pd_tab[j] & 8'h70);
    end
    wr(13'h177, 8'hff);
    repeat (2) @(posedge clk);
    #1;
    check_val("ref_out", 8'h01, {7'h0, ref_rst});
    rd_chk("ref_rb", 13'h177, 8'hff, 8'h20);
    @(posedge clk);
    ce <= 1'b0;
    wr(13'h177, 8'h00);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_val("ref_hold", 8'h01, {7'h0, ref_rst});
    wr(13'h177, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check_val("ref_off", 8'h00, {7'h0, ref_rst});
    wr(13'h183, 8'hff);
    wr(13'h16f, 8'hff);
    rd_chk("unmapped", 13'h100, 8'hff, 8'h00);
    rd_chk("cfg_kept", 13'h16e, 8'hff, 8'h06);
    rd_chk("rb_resv", 13'h183, 8'hf0, 8'h00);
    for (int s = 0; s < 21; s++)
    begin
      wr(13'h16e, {(s == 20) ? 5'h1f : 5'(s), 3'h3});
      foreach (pat_tab[p])
      begin
        drive_in(pat_tab[p]);
        check_pin(exp_pin(3'h3, exp_level((s == 20) ? 5'h1f : 5'(s), pat_tab[p], 5'h00)));
      end
    end
    for (int f = 2; f < 4; f++)
    begin
      @(posedge clk);
      first_sel <= 5'(f);
      for (int s = 17; s < 19; s++)
      begin
        wr(13'h16e, {5'(s), 3'h3});
        drive_in(16'hffff);
        check_pin(2'b10);
      end
    end
    @(posedge clk);
    first_sel <= 5'h00;
    for (int d = 0; d < 8; d++)
    begin
      wr(13'h16e, {5'h01, 3'(d)});
      drive_in(16'h0001);
      check_pin(exp_pin(3'(d), 1'b1));
      drive_in(16'h0000);
      check_pin(exp_pin(3'(d), 1'b0));
    end
    wr(13'h16e, 8'h06);
    @(posedge clk);
    force_on <= 1'b1;
    drive_in(16'h0003);
    wr(13'h182, 8'h03);
    wr(13'h182, 8'h00);
    rd_chk("rb_clean", 13'h183, 8'h0f, 8'h05);
    flag_seq(1);
    flag_seq(0);
    @(posedge clk);
    force_on <= 1'b0;
    drive_in(src);
    check_val("run_off", 8'h00, {7'h0, run});
    rd_chk("rb_invalid", 13'h183, 8'h01, 8'h00);
    wr(13'h16e, {5'h02, 3'h6});
    drive_in(src);
    check_val("run_pin2", 8'h01, {7'h0, run});
    wr(13'h16e, 8'h06);
    @(posedge clk);
    first_sel <= 5'h03;
    drive_in(src);
    check_val("run_pin1", 8'h01, {7'h0, run});
    @(posedge clk);
    first_sel <= 5'h00;
    force_on  <= 1'b1;
    drive_in(src);
    check_val("run_force", 8'h01, {7'h0, run});
    rd_chk("rb_valid", 13'h183, 8'h01, 8'h01);
    print_verdict();
  end
endmodule // lock_status_misc_control_tb

`default_nettype wire
